// ==== inc/led_blink_pkg.sv ====
`default_nettype none
package led_blink_pkg;

   // Register offsets on the device register port
   localparam logic [7:0] RANGE_PHASE_BRIGHTNESS_OFS = 8'h41;
   localparam logic [7:0] PERIOD_DUTY_OFS = 8'h44;

   // Reset values
   localparam logic [7:0] RANGE_PHASE_BRIGHTNESS_RST = 8'h04;
   localparam logic [7:0] PERIOD_DUTY_RST = 8'h0f;

   // Field positions, range/invert/brightness register
   localparam int RANGE_MSB = 7;
   localparam int RANGE_LSB = 6;
   localparam int INVERT_BIT = 5;
   localparam int BRIGHT_MSB = 4;
   localparam int BRIGHT_LSB = 0;

   // Field positions, period/duty register
   localparam int PERIOD_MSB = 7;
   localparam int PERIOD_LSB = 4;
   localparam int DUTY_MSB = 3;
   localparam int DUTY_LSB = 0;

   // Range codes and their full-scale currents in microamps
   localparam logic [1:0] RANGE_OFF = 2'h0;
   localparam logic [1:0] RANGE_LOW = 2'h1;
   localparam logic [1:0] RANGE_MID = 2'h2;
   localparam logic [1:0] RANGE_HIGH = 2'h3;
   localparam logic [13:0] FULL_SCALE_LOW_UA = 14'h0c80;
   localparam logic [13:0] FULL_SCALE_MID_UA = 14'h1900;
   localparam logic [13:0] FULL_SCALE_HIGH_UA = 14'h3200;

   // Timing: one period step, split into sixteen duty slots
   localparam int CLK_KHZ = 20000;
   localparam int PERIOD_STEP_MS = 500;
   localparam int DUTY_SLOTS = 16;
   localparam int SLOT_CYCLES = PERIOD_STEP_MS * CLK_KHZ / DUTY_SLOTS;

   typedef enum logic [1:0] {
      ST_DARK = 2'b01,
      ST_BLINK = 2'b10
   } run_state_t;

endpackage
`default_nettype wire

// ==== inc/led_timer_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface led_timer_if;
   logic run;
   logic [3:0] period_code;
   logic [3:0] duty_code;
   logic in_duty;
   logic period_start;

   modport ctrl (output run, output period_code, output duty_code,
                 input in_duty, input period_start);
   modport timer (input run, input period_code, input duty_code,
                  output in_duty, output period_start);
endinterface
`default_nettype wire

// ==== hdl/led_blink_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
module led_blink_timer #(
   parameter int SLOT_CYCLES = led_blink_pkg::SLOT_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Control side
   led_timer_if.timer tmr
);
   import led_blink_pkg::*;

   logic [19:0] tick_cnt;
   logic tick;
   logic [3:0] sub_cnt;
   logic [3:0] slot;
   logic [3:0] held_period;
   logic [3:0] held_duty;
   logic last_slot_end;

   // Slot tick divider; held at zero while idle so a new run starts aligned
   always_ff @(posedge mclk) begin
      if (reset || !tmr.run) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else if (tick_cnt == 20'(SLOT_CYCLES - 1)) begin
         tick_cnt <= '0;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 20'h1;
         tick <= 1'b0;
      end
   end

   assign last_slot_end = tick && (sub_cnt == held_period) && (slot == 4'hf);

   // Each slot lasts period_code+1 ticks, sixteen slots make a period
   always_ff @(posedge mclk) begin
      if (reset || !tmr.run) begin
         sub_cnt <= '0;
         slot <= '0;
      end else if (tick) begin
         if (sub_cnt == held_period) begin
            sub_cnt <= '0;
            slot <= slot + 4'h1;
         end else begin
            sub_cnt <= sub_cnt + 4'h1;
         end
      end
   end

   // New codes land only while idle or at a period boundary, so no shortened pulses
   always_ff @(posedge mclk) begin
      if (reset) begin
         held_period <= PERIOD_DUTY_RST[PERIOD_MSB:PERIOD_LSB];
         held_duty <= PERIOD_DUTY_RST[DUTY_MSB:DUTY_LSB];
      end else if (!tmr.run || last_slot_end) begin
         held_period <= tmr.period_code;
         held_duty <= tmr.duty_code;
      end
   end

   assign tmr.in_duty = (slot <= held_duty);
   assign tmr.period_start = last_slot_end;
endmodule // led_blink_timer
`default_nettype wire

// ==== hdl/led_blink_channel.sv ====
// Overview of operation
// - Range code 00 disables; 01, 10, 11 give 3.2, 6.4, 12.8 mA full scale.
// - Sink drives only with master enable set and software on or on/off controller in an On state.
// - Invert 0: period starts on for the duty fraction, then off.
// - Invert 1: period starts off for the duty fraction, then on.
// - On-current follows the 5-bit brightness code within the chosen range.
// - Period code n gives a period of 0.5 s times (n+1).
// - Duty code n gives (n+1) sixteenths of the period.
// - Range/invert/brightness register resets to 0x04.
// - Period/duty register resets to 0x0f.
`timescale 1ns/10ps
`default_nettype none
module led_blink_channel #(
   parameter int SLOT_CYCLES = led_blink_pkg::SLOT_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Register port from the serial host interface
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   // Global gating
   input wire logic led_master_enable,
   input wire logic on_by_software,
   input wire logic on_by_controller,
   // Current sink control
   output logic sink_on,
   output logic [4:0] brightness_code,
   output logic [1:0] full_scale_range_sel,
   output logic [13:0] full_scale_ua,
   output logic period_mark
);
   import led_blink_pkg::*;

   led_timer_if tmr_bus ();

   logic [7:0] range_phase_brightness;
   logic [7:0] period_duty;
   logic phase_invert;
   logic [3:0] blink_period_code;
   logic [3:0] on_duty_code;
   logic [1:0] range_field;
   logic [4:0] bright_field;
   logic allowed;
   logic is_a;
   logic is_b;
   run_state_t state;
   run_state_t next_state;

   // Register decode, shared by write and read paths
   function automatic logic addr_match(input logic [7:0] addr, input logic [7:0] ofs);
      addr_match = (addr == ofs);
   endfunction

   // Range code to full-scale current in microamps
   function automatic logic [13:0] range_to_ua(input logic [1:0] code);
      case (code)
         RANGE_LOW: range_to_ua = FULL_SCALE_LOW_UA;
         RANGE_MID: range_to_ua = FULL_SCALE_MID_UA;
         RANGE_HIGH: range_to_ua = FULL_SCALE_HIGH_UA;
         default: range_to_ua = '0;
      endcase
   endfunction

   assign is_a = addr_match(reg_addr, RANGE_PHASE_BRIGHTNESS_OFS);
   assign is_b = addr_match(reg_addr, PERIOD_DUTY_OFS);

   // Field views
   assign range_field = range_phase_brightness[RANGE_MSB:RANGE_LSB];
   assign phase_invert = range_phase_brightness[INVERT_BIT];
   assign bright_field = range_phase_brightness[BRIGHT_MSB:BRIGHT_LSB];
   assign blink_period_code = period_duty[PERIOD_MSB:PERIOD_LSB];
   assign on_duty_code = period_duty[DUTY_MSB:DUTY_LSB];

   // Range/invert/brightness register
   always_ff @(posedge mclk) begin
      if (reset) begin
         range_phase_brightness <= RANGE_PHASE_BRIGHTNESS_RST;
      end else if (reg_write && is_a) begin
         range_phase_brightness <= reg_wdata;
      end
   end

   // Period/duty register
   always_ff @(posedge mclk) begin
      if (reset) begin
         period_duty <= PERIOD_DUTY_RST;
      end else if (reg_write && is_b) begin
         period_duty <= reg_wdata;
      end
   end

   // Read path; unmapped offsets answer zero with reg_hit low
   always_ff @(posedge mclk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
         reg_hit <= 1'b0;
      end else if (reg_read) begin
         reg_hit <= is_a || is_b;
         if (is_a) begin
            reg_rdata <= range_phase_brightness;
         end else if (is_b) begin
            reg_rdata <= period_duty;
         end else begin
            reg_rdata <= 8'h00;
         end
      end else begin
         reg_hit <= 1'b0;
      end
   end

   // Channel may run only with range not off, master enable set, and software or controller on
   assign allowed = (range_field != RANGE_OFF)
      && led_master_enable && (on_by_software || on_by_controller);

   always_comb begin
      next_state = state;
      case (state)
         ST_DARK: begin
            if (allowed) begin
               next_state = ST_BLINK;
            end
         end
         ST_BLINK: begin
            if (!allowed) begin
               next_state = ST_DARK;
            end
         end
         default: next_state = ST_DARK;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= ST_DARK;
      end else begin
         state <= next_state;
      end
   end

   // Timer restarts from a fresh period each time the channel is enabled
   assign tmr_bus.run = (state == ST_BLINK) && allowed;
   assign tmr_bus.period_code = blink_period_code;
   assign tmr_bus.duty_code = on_duty_code;

   led_blink_timer #(
      .SLOT_CYCLES(SLOT_CYCLES)
   ) u_timer (
      .mclk(mclk),
      .reset(reset),
      .tmr(tmr_bus.timer)
   );

   // Sink switching; inverted phase swaps the on and off portions
   always_ff @(posedge mclk) begin
      if (reset) begin
         sink_on <= 1'b0;
      end else if (!tmr_bus.run) begin
         sink_on <= 1'b0;
      end else if (!phase_invert) begin
         sink_on <= tmr_bus.in_duty;
      end else begin
         sink_on <= !tmr_bus.in_duty;
      end
   end

   // Analog settings to the sink; brightness is scaled there
   always_ff @(posedge mclk) begin
      if (reset) begin
         brightness_code <= RANGE_PHASE_BRIGHTNESS_RST[BRIGHT_MSB:BRIGHT_LSB];
         full_scale_range_sel <= RANGE_OFF;
         full_scale_ua <= '0;
      end else begin
         brightness_code <= bright_field;
         full_scale_range_sel <= range_field;
         full_scale_ua <= range_to_ua(range_field);
      end
   end

   // One-cycle pulse marking each period boundary while running
   always_ff @(posedge mclk) begin
      if (reset) begin
         period_mark <= 1'b0;
      end else begin
         period_mark <= tmr_bus.run && tmr_bus.period_start;
      end
   end
endmodule // led_blink_channel
`default_nettype wire

// ==== dv/led_blink_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module led_blink_monitor #(parameter int SLOT_CYCLES = led_blink_pkg::SLOT_CYCLES) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit,
   // Gating
   input wire logic led_master_enable,
   input wire logic on_by_software,
   input wire logic on_by_controller,
   // Sink
   input wire logic sink_on,
   input wire logic [4:0] brightness_code,
   input wire logic [1:0] full_scale_range_sel,
   input wire logic [13:0] full_scale_ua,
   input wire logic period_mark
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   wire logic gate = led_master_enable && (on_by_software || on_by_controller)
      && full_scale_range_sel != 2'h0;
   wire logic mapped = reg_addr == 8'h41 || reg_addr == 8'h44;
   int gap = 0;
   logic armed = 1'b0;
   // Gap only trusted once a mark has come with gating steady
   always_ff @(posedge mclk) begin
      gap <= period_mark ? 1 : gap + 1;
   end
   always_ff @(posedge mclk) begin
      armed <= !reset && gate && $past(gate, 3) && (period_mark || armed);
   end
   sequence s_wr_a;
      reg_write && reg_addr == 8'h41 ##1 !reg_write;
   endsequence
   property p_ua;
      full_scale_ua == (full_scale_range_sel == 2'h0 ? 14'h0000 :
         14'h0c80 << (full_scale_range_sel - 2'h1));
   endproperty
   property p_master;
      !led_master_enable [*3] |=> !sink_on;
   endproperty
   property p_off;
      full_scale_range_sel == 2'h0 [*3] |=> !sink_on;
   endproperty
   property p_reset;
      disable iff (1'b0) reset |=> !sink_on && brightness_code == 5'h04
         && full_scale_range_sel == 2'h0 && full_scale_ua == 14'h0000;
   endproperty
   property p_hit;
      reg_read && mapped |=> reg_hit;
   endproperty
   property p_miss;
      reg_read && !mapped |=> !reg_hit && reg_rdata == 8'h00;
   endproperty
   property p_fields;
      s_wr_a |=> brightness_code == $past(reg_wdata[4:0], 2)
         && full_scale_range_sel == $past(reg_wdata[7:6], 2);
   endproperty
   property p_hold;
      !reg_read |=> $stable(reg_rdata);
   endproperty
   property p_period;
      period_mark && armed |-> gap % (16 * SLOT_CYCLES) == 0;
   endproperty
   a_ua: assert property (p_ua) else $error("full scale mismatch");
   a_master: assert property (p_master) else $error("sink on unmastered");
   a_off: assert property (p_off) else $error("sink on in range off");
   a_reset: assert property (p_reset) else $error("bad reset outputs");
   a_hit: assert property (p_hit) else $error("no hit on read");
   a_miss: assert property (p_miss) else $error("unmapped read hit");
   a_fields: assert property (p_fields) else $error("fields not copied");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_period: assert property (p_period) else $error("period length off");
endmodule // led_blink_monitor
bind led_blink_channel led_blink_monitor #(.SLOT_CYCLES(SLOT_CYCLES)) mon (
   .mclk(mclk),
   .reset(reset),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_write(reg_write),
   .reg_read(reg_read),
   .reg_rdata(reg_rdata),
   .reg_hit(reg_hit),
   .led_master_enable(led_master_enable),
   .on_by_software(on_by_software),
   .on_by_controller(on_by_controller),
   .sink_on(sink_on),
   .brightness_code(brightness_code),
   .full_scale_range_sel(full_scale_range_sel),
   .full_scale_ua(full_scale_ua),
   .period_mark(period_mark)
);
`default_nettype wire

// ==== dv/led_blink_channel_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module led_blink_channel_tb;
   import led_blink_pkg::*;
   localparam int S = 4;
   logic mclk = 0, reset = 1, reg_write = 0, reg_read = 0;
   logic led_master_enable = 0, on_by_software = 0, on_by_controller = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_hit, sink_on, period_mark;
   logic [4:0] brightness_code;
   logic [1:0] full_scale_range_sel;
   logic [13:0] full_scale_ua;
   logic [31:0] seed = 32'h15b3c00f;
   int fail_count = 0, checks = 0;
   always #25 mclk = ~mclk;
   led_blink_channel #(.SLOT_CYCLES(S)) dut (
      .mclk(mclk),
      .reset(reset),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_write(reg_write),
      .reg_read(reg_read),
      .reg_rdata(reg_rdata),
      .reg_hit(reg_hit),
      .led_master_enable(led_master_enable),
      .on_by_software(on_by_software),
      .on_by_controller(on_by_controller),
      .sink_on(sink_on),
      .brightness_code(brightness_code),
      .full_scale_range_sel(full_scale_range_sel),
      .full_scale_ua(full_scale_ua),
      .period_mark(period_mark)
   );
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Full scale doubles per range step above the lowest
   function automatic logic [13:0] exp_ua(logic [1:0] code);
      return code == 2'h0 ? 14'h0000 : FULL_SCALE_LOW_UA << (code - 2'h1);
   endfunction
   task automatic tick(int n = 1);
      repeat (n) @(posedge mclk);
      #5;
   endtask
   task automatic complete_run();
      if (fail_count == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   // Strobe low for a cycle between requests keeps drivers single-assigned
   task automatic wr(logic [7:0] a, logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1;
      tick();
      reg_write = 0;
      tick();
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] exp, logic hit);
      reg_addr = a;
      reg_read = 1;
      tick();
      reg_read = 0;
      chk("reg_rdata", reg_rdata, exp);
      chk("reg_hit", reg_hit, hit);
      tick();
   endtask
   // New period/duty written just after a mark must wait for the next one
   task automatic period_run(logic [7:0] cur, logic [7:0] nxt, logic inv);
      int len = 0, on = 0, n = 0, p = cur[7:4], d = cur[3:0], hi;
      while (period_mark !== 1'b1 && n < 3000) begin
         tick();
         n++;
      end
      reg_addr = 8'h44;
      reg_wdata = nxt;
      reg_write = 1;
      // Sink lags the slot by one edge, so count from the edge after the mark
      do begin
         tick();
         reg_write = 0;
         len++;
         on += (sink_on === 1'b1);
      end while (period_mark !== 1'b1 && len < 2000);
      hi = (d + 1) * (p + 1) * S;
      chk("period length", len, 16 * (p + 1) * S);
      chk("on cycles", on, inv ? 16 * (p + 1) * S - hi : hi);
   endtask
   initial begin
      logic [7:0] cfg [4];
      logic [31:0] b;
      tick(8);
      reset = 0;
      rd(8'h41, 8'h04, 1);
      rd(8'h44, 8'h0f, 1);
      rd(8'h43, 8'h00, 0);
      repeat (8) begin
         b = rnd();
         wr(8'h41, b[7:0]);
         rd(8'h41, b[7:0], 1);
         chk("brightness", brightness_code, b[4:0]);
         chk("full scale", full_scale_ua, exp_ua(b[7:6]));
         wr(8'h44, b[15:8]);
         rd(8'h44, b[15:8], 1);
      end
      wr(8'h41, 8'h00);
      wr(8'h44, 8'h0f);
      for (int i = 0; i < 32; i++) begin
         {led_master_enable, on_by_software, on_by_controller} = i[2:0];
         wr(8'h41, {i[4:3], 6'h1f});
         tick(4);
         chk("sink gate", sink_on, i[4:3] != 0 && i[2] && i[1:0] != 0);
      end
      for (int v = 0; v < 2; v++) begin
         cfg = '{8'h00, 8'hf5, 8'h2f, 8'(rnd()) & 8'h3f};
         wr(8'h41, 8'h00);
         wr(8'h44, cfg[0]);
         wr(8'h41, {2'h3, v[0], 5'h04});
         for (int k = 0; k < 3; k++) period_run(cfg[k], cfg[k + 1], v[0]);
      end
      complete_run();
   end
   initial begin
      #(20000 * 50);
      fail_count++;
      complete_run();
   end
endmodule // led_blink_channel_tb
`default_nettype wire
